// ### common/ds3_pm_consts.vh
// Constants for the receive-side performance monitor
`ifndef DS3_PM_CONSTS_VH
`define DS3_PM_CONSTS_VH
// Register byte offsets
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_CHANGE    8'h08
`define REG_FRM_CNT   8'h0c
`define REG_PAR_CNT   8'h10
`define REG_CPAR_CNT  8'h14
`define REG_FAR_BLOCK_ERROR_CNT  8'h18
// Control fields
`define CTRL_CBIT     0
`define CTRL_MFOOF    1
`define CTRL_LOFT_LO  2
`define CTRL_FEM_LO   4
`define CTRL_RAI_LO   6
`define CTRL_RESYNC   10
`define CTRL_FAR_BLOCK_ERROR_EN  11
`define CTRL_RESET    12'h fc3
// Status / change bit positions
`define ST_MULTIFRAME_MISALIGN 0
`define ST_OOF  1
`define ST_SEF  2
`define ST_LOF  3
`define ST_LOS  4
`define ST_AIS  5
`define ST_RUA  6
`define ST_IDLE 7
`define ST_RDI  8
`define ST_FM   9
`define ST_AIC  10
`define ST_ALIGNMENT_CHANGE 11
// Overhead kinds
`define OH_PAY 3'h0
`define OH_F   3'h1
`define OH_M   3'h2
`define OH_X   3'h3
`define OH_P   3'h4
`define OH_C   3'h5
// Framing error criteria
`define FEM_OOF 2'h0
`define FEM_FM  2'h1
`define FEM_F   2'h2
`define FEM_M   2'h3
// Thresholds
`define MIS_MAX     4'h7
`define INTEG_FRAMES 10
`define RUA_WINDOW  2047
`define RUA_ZEROS   3'h5
`define AIC_ONES    31
`define AIC_ZEROS   4
// Timing
`define MS_NS  1000000
`define CLK_NS 25
`endif

// ### hdl/ds3_rx_perf_monitor.v
// DS3 receive performance monitor with AXI4-Lite register access
`timescale 1ns/1ps
`include "ds3_pm_consts.vh"
module ds3_rx_perf_monitor #(
  parameter CNT_W     = 16,
  parameter MS_CYCLES = `MS_NS / `CLK_NS
) (
  input  wire             mclk,
  input  wire             sys_rst,
  input  wire             bitValid,
  input  wire             lineBit,
  input  wire [2:0]       ohType,
  input  wire [2:0]       ohSub,
  input  wire [1:0]       ohPos,
  input  wire             frameEnd,
  input  wire             frameLoad,
  input  wire             loadAlignDiff,
  input  wire             decoderActive,
  input  wire             decoderLos,
  input  wire             rxFormatCbit,
  output reg              rxAlarmIndication,
  output reg              febeRequest,
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready
);

  function [4:0] ones32;
    input [31:0] v;
    integer i;
    begin
      ones32 = 5'h00;
      for (i = 0; i < 32; i = i + 1)
        ones32 = ones32 + {4'h0, v[i]};
    end
  endfunction

  reg  [11:0]      ctrl_q;
  reg  [11:0]      change_q;
  reg  [11:0]      statusPrev_q;
  reg  [CNT_W-1:0] frmCnt_q, parCnt_q, cparCnt_q, febeCnt_q;
  // Frame accumulators
  reg  [4:0]  fErr_q;
  reg  [1:0]  mErr_q;
  reg  [1:0]  phase_q;
  reg  [3:0]  aisMis_q, idleMis_q;
  reg         parity_q, prevParity_q, prevValid_q;
  reg         xAll1_q, xAll0_q, cAll0_q;
  reg  [1:0]  pBits_q;
  reg  [2:0]  c3_q, c4_q;
  reg         c11_q;
  // Alarm state
  reg  [15:0] fHist_q;
  reg  [3:0]  mHist_q;
  reg         multiframe_misalign_q, oof_q, sef_q, lof_q, ais_q, idle_q, rdi_q, rua_q;
  reg         aic_q, alignment_change_q;
  reg  [1:0]  lofInteg_q, lofAbsent_q;
  reg  [31:0] msCnt_q;
  reg  [4:0]  aisTot_q, aisAbs_q, idleTot_q, idleAbs_q;
  reg  [2:0]  rdiSet_q, rdiClr_q;
  reg  [10:0] ruaBits_q;
  reg  [2:0]  ruaZeros_q;
  reg         ruaOofAll_q, ruaOofNone_q;
  reg  [2:0]  ruaGood_q, ruaBad_q;
  reg  [30:0] c11Hist_q;
  reg  [4:0]  c11Ones_q;
  // AXI slave state
  reg         awHeld_q, wHeld_q;
  reg  [7:0]  awAddr_q;
  reg  [31:0] wData_q;
  reg  [3:0]  wStrb_q;

  wire [1:0] lofT   = ctrl_q[`CTRL_LOFT_LO+1:`CTRL_LOFT_LO];
  wire [1:0] feMode = ctrl_q[`CTRL_FEM_LO+1:`CTRL_FEM_LO];
  wire [3:0] raiEn  = ctrl_q[`CTRL_RAI_LO+3:`CTRL_RAI_LO];
  wire       cfgCbit = ctrl_q[`CTRL_CBIT];
  wire       signal_loss    = decoderActive & decoderLos;
  wire       fmis   = rxFormatCbit != cfgCbit;

  // AXI write: address and data taken in either order
  wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
  assign s_axi_awready = ~awHeld_q;
  assign s_axi_wready  = ~wHeld_q;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wrCtrl   = doWrite & (awAddr_q == `REG_CTRL);
  wire wrChange = doWrite & (awAddr_q == `REG_CHANGE);
  wire wrFrm    = doWrite & (awAddr_q == `REG_FRM_CNT);
  wire wrPar    = doWrite & (awAddr_q == `REG_PAR_CNT);
  wire wrCpar   = doWrite & (awAddr_q == `REG_CPAR_CNT);
  wire wrFebe   = doWrite & (awAddr_q == `REG_FAR_BLOCK_ERROR_CNT);
  wire wrKnown  = (awAddr_q[7:2] <= 6'h06) & (awAddr_q[1:0] == 2'h0)
                  & (awAddr_q != `REG_STATUS);
  wire resync   = wrCtrl & wStrb_q[1] & wData_q[`CTRL_RESYNC];

  // Frame-level verdicts, valid in the frameEnd cycle
  wire       fmValid  = (fErr_q == 5'h00) & (mErr_q == 2'h0);
  wire       pErr     = prevValid_q & ((pBits_q[0] != prevParity_q) |
                                       (pBits_q[1] != prevParity_q));
  wire       cErr     = prevValid_q & cfgCbit &
                        (c3_q != {3{prevParity_q}});
  wire       febeErr  = cfgCbit & (c4_q != 3'h7);
  wire       aisPres  = fmValid & xAll1_q & (pBits_q == 2'h0) &
                        cAll0_q & (aisMis_q <= `MIS_MAX);
  wire       idlePres = fmValid & ~pErr & prevValid_q & xAll1_q &
                        (~cfgCbit | (c3_q == 3'h0)) &
                        (idleMis_q <= `MIS_MAX);
  wire [3:0] mHistNew = {mHist_q[2:0], mErr_q != 2'h0};
  wire [4:0] fOnes    = ones32({16'h0000, fHist_q});
  wire [4:0] mOnes    = ones32({28'h0, mHistNew});
  wire       fSet     = fOnes >= 5'h03;
  wire       oofRise  = ~oof_q & (fSet | resync |
                        (ctrl_q[`CTRL_MFOOF] & multiframe_misalign_q));
  wire       holdAic  = signal_loss | oof_q | ais_q;
  wire [30:0] c11New  = {c11Hist_q[29:0], c11_q};
  wire [4:0] c11Zeros = 5'h1f - ones32({1'b0, c11New});
  wire       msTick   = msCnt_q == MS_CYCLES - 1;
  wire       ruaEnd   = bitValid & (ruaBits_q == `RUA_WINDOW - 1);

  // Framing error increment per selected criterion
  reg [5:0] frmInc;
  always @* begin
    frmInc = 6'h00;
    case (feMode)
      `FEM_OOF: frmInc = {5'h00, oofRise};
      `FEM_FM:  frmInc = frameEnd ? {1'b0, fErr_q} + {4'h0, mErr_q} : 6'h00;
      `FEM_F:   frmInc = frameEnd ? {1'b0, fErr_q} : 6'h00;
      `FEM_M:   frmInc = frameEnd ? {4'h0, mErr_q} : 6'h00;
      default:  frmInc = 6'h00;
    endcase
  end

  wire [11:0] status = {alignment_change_q, aic_q, fmis, rdi_q, idle_q, rua_q, ais_q,
                        signal_loss, lof_q, sef_q, oof_q, multiframe_misalign_q};

  // Per-bit accumulation; the overhead bit restarts the payload pattern
  always @(posedge mclk) begin
    if (sys_rst | frameEnd) begin
      fErr_q <= 5'h00; mErr_q <= 2'h0; phase_q <= 2'h0;
      aisMis_q <= 4'h0; idleMis_q <= 4'h0; parity_q <= 1'b0;
      xAll1_q <= 1'b1; xAll0_q <= 1'b1; cAll0_q <= 1'b1;
      pBits_q <= 2'h0; c3_q <= 3'h0; c4_q <= 3'h7; c11_q <= 1'b0;
    end else if (bitValid) begin
      phase_q <= (ohType == `OH_PAY) ? phase_q + 2'h1 : 2'h0;
      case (ohType)
        `OH_PAY: begin
          parity_q <= parity_q ^ lineBit;
          if (lineBit == phase_q[0] && aisMis_q != 4'hf)
            aisMis_q <= aisMis_q + 4'h1;
          if (lineBit == phase_q[1] && idleMis_q != 4'hf)
            idleMis_q <= idleMis_q + 4'h1;
        end
        `OH_F: if (lineBit != (ohPos == 2'h0 || ohPos == 2'h3))
          fErr_q <= fErr_q + 5'h01;
        `OH_M: if (lineBit != (ohPos == 2'h1))
          mErr_q <= mErr_q + 2'h1;
        `OH_X: begin
          xAll1_q <= xAll1_q & lineBit;
          xAll0_q <= xAll0_q & ~lineBit;
        end
        `OH_P: pBits_q[ohPos[0]] <= lineBit;
        `OH_C: begin
          cAll0_q <= cAll0_q & ~lineBit;
          if (ohSub == 3'h3) c3_q[ohPos] <= lineBit;
          if (ohSub == 3'h4) c4_q[ohPos] <= lineBit;
          if (ohSub == 3'h1 && ohPos == 2'h0) c11_q <= lineBit;
        end
        default: phase_q <= 2'h0;
      endcase
    end
  end

  // Misalignment conditions; reload clears, resync declares
  always @(posedge mclk) begin
    if (sys_rst) begin
      fHist_q <= 16'h0000; mHist_q <= 4'h0;
      multiframe_misalign_q <= 1'b0; oof_q <= 1'b0; sef_q <= 1'b0; alignment_change_q <= 1'b0;
      prevParity_q <= 1'b0; prevValid_q <= 1'b0;
    end else begin
      alignment_change_q <= frameLoad & loadAlignDiff;
      if (bitValid && ohType == `OH_F)
        fHist_q <= {fHist_q[14:0],
                    lineBit != (ohPos == 2'h0 || ohPos == 2'h3)};
      if (frameEnd) begin
        mHist_q <= mHistNew;
        prevParity_q <= parity_q;
        prevValid_q <= 1'b1;
      end
      if (resync)
        multiframe_misalign_q <= 1'b1;
      else if (frameLoad)
        multiframe_misalign_q <= 1'b0;
      else if (frameEnd && mOnes >= 5'h02)
        multiframe_misalign_q <= 1'b1;
      else if (frameEnd && mHistNew == 4'h0)
        multiframe_misalign_q <= 1'b0;
      if (resync || (!frameLoad && oofRise))
        oof_q <= 1'b1;
      else if (frameLoad)
        oof_q <= 1'b0;
      else if (fHist_q == 16'h0000 &&
               (!ctrl_q[`CTRL_MFOOF] || !multiframe_misalign_q))
        oof_q <= 1'b0;
      if (fSet || resync)
        sef_q <= 1'b1;
      else if (!oof_q)
        sef_q <= 1'b0;
    end
  end

  // Frame loss integration on a millisecond tick
  always @(posedge mclk) begin
    if (sys_rst) begin
      msCnt_q <= 32'h0; lofInteg_q <= 2'h0; lofAbsent_q <= 2'h0;
      lof_q <= 1'b0;
    end else begin
      msCnt_q <= msTick ? 32'h0 : msCnt_q + 32'h1;
      if (oof_q) begin
        lofAbsent_q <= 2'h0;
        if (msTick && lofInteg_q != 2'h3)
          lofInteg_q <= lofInteg_q + 2'h1;
        if (lofInteg_q >= lofT)
          lof_q <= 1'b1;
      end else begin
        if (msTick && lofAbsent_q != 2'h3)
          lofAbsent_q <= lofAbsent_q + 2'h1;
        if (lofAbsent_q >= lofT) begin
          lofInteg_q <= 2'h0;
          lof_q <= 1'b0;
        end
      end
    end
  end

  // Frame-rate integrators: alarm signal, idle, remote defect, app id
  always @(posedge mclk) begin
    if (sys_rst) begin
      aisTot_q <= 5'h00; aisAbs_q <= 5'h00; ais_q <= 1'b0;
      idleTot_q <= 5'h00; idleAbs_q <= 5'h00; idle_q <= 1'b0;
      rdiSet_q <= 3'h0; rdiClr_q <= 3'h0; rdi_q <= 1'b0;
      c11Hist_q <= 31'h0; c11Ones_q <= 5'h00; aic_q <= 1'b0;
    end else if (frameEnd) begin
      if (aisPres) begin
        aisAbs_q <= 5'h00;
        if (aisTot_q != `INTEG_FRAMES) aisTot_q <= aisTot_q + 5'h01;
        if (aisTot_q + 5'h01 >= `INTEG_FRAMES) ais_q <= 1'b1;
      end else if (aisAbs_q + 5'h01 >= `INTEG_FRAMES) begin
        aisAbs_q <= 5'h00; aisTot_q <= 5'h00; ais_q <= 1'b0;
      end else
        aisAbs_q <= aisAbs_q + 5'h01;
      if (idlePres) begin
        idleAbs_q <= 5'h00;
        if (idleTot_q != `INTEG_FRAMES) idleTot_q <= idleTot_q + 5'h01;
        if (idleTot_q + 5'h01 >= `INTEG_FRAMES) idle_q <= 1'b1;
      end else if (idleAbs_q + 5'h01 >= `INTEG_FRAMES) begin
        idleAbs_q <= 5'h00; idleTot_q <= 5'h00; idle_q <= 1'b0;
      end else
        idleAbs_q <= idleAbs_q + 5'h01;
      // Runs of four; a frame with mixed X-bits breaks both runs
      rdiSet_q <= xAll0_q ? (rdiSet_q == 3'h4 ? 3'h4 : rdiSet_q + 3'h1)
                          : 3'h0;
      rdiClr_q <= xAll1_q ? (rdiClr_q == 3'h4 ? 3'h4 : rdiClr_q + 3'h1)
                          : 3'h0;
      if (xAll0_q && rdiSet_q == 3'h3) rdi_q <= 1'b1;
      if (xAll1_q && rdiClr_q == 3'h3) rdi_q <= 1'b0;
      c11Hist_q <= c11New;
      c11Ones_q <= c11_q ? (c11Ones_q == `AIC_ONES ? c11Ones_q
                            : c11Ones_q + 5'h01) : 5'h00;
      if (!holdAic) begin
        if (c11_q && c11Ones_q + 5'h01 >= `AIC_ONES) aic_q <= 1'b1;
        else if (c11Zeros >= `AIC_ZEROS) aic_q <= 1'b0;
      end
    end
  end

  // Unframed all-ones over fixed 2047-bit windows
  always @(posedge mclk) begin
    if (sys_rst) begin
      ruaBits_q <= 11'h000; ruaZeros_q <= 3'h0; ruaOofAll_q <= 1'b1;
      ruaOofNone_q <= 1'b1; ruaGood_q <= 3'h0; ruaBad_q <= 3'h0;
      rua_q <= 1'b0;
    end else if (bitValid) begin
      if (ruaEnd) begin
        ruaBits_q <= 11'h000; ruaZeros_q <= 3'h0;
        ruaOofAll_q <= 1'b1; ruaOofNone_q <= 1'b1;
        if (ruaZeros_q <= `RUA_ZEROS && ruaOofAll_q && oof_q) begin
          ruaBad_q <= 3'h0;
          ruaGood_q <= ruaGood_q == 3'h4 ? 3'h4 : ruaGood_q + 3'h1;
          if (ruaGood_q >= 3'h3) rua_q <= 1'b1;
        end else begin
          ruaGood_q <= 3'h0;
          if (ruaZeros_q > `RUA_ZEROS)
            ruaBad_q <= ruaBad_q == 3'h4 ? 3'h4 : ruaBad_q + 3'h1;
          else
            ruaBad_q <= 3'h0;
          if ((ruaZeros_q > `RUA_ZEROS && ruaBad_q >= 3'h3) ||
              (ruaOofNone_q && !oof_q))
            rua_q <= 1'b0;
        end
      end else begin
        ruaBits_q <= ruaBits_q + 11'h001;
        if (!lineBit && ruaZeros_q != 3'h7)
          ruaZeros_q <= ruaZeros_q + 3'h1;
        ruaOofAll_q <= ruaOofAll_q & oof_q;
        ruaOofNone_q <= ruaOofNone_q & ~oof_q;
      end
    end
  end

  // Saturating error counters; a software write clears
  always @(posedge mclk) begin
    if (sys_rst) begin
      frmCnt_q <= {CNT_W{1'b0}}; parCnt_q <= {CNT_W{1'b0}};
      cparCnt_q <= {CNT_W{1'b0}}; febeCnt_q <= {CNT_W{1'b0}};
    end else begin
      if (wrFrm)
        frmCnt_q <= {CNT_W{1'b0}};
      else if ({{CNT_W{1'b0}}, frmInc} + {6'h0, frmCnt_q} >
               {6'h0, {CNT_W{1'b1}}})
        frmCnt_q <= {CNT_W{1'b1}};
      else
        frmCnt_q <= frmCnt_q + {{(CNT_W-6){1'b0}}, frmInc};
      if (wrPar) parCnt_q <= {CNT_W{1'b0}};
      else if (frameEnd && pErr && ~&parCnt_q)
        parCnt_q <= parCnt_q + 1'b1;
      if (wrCpar) cparCnt_q <= {CNT_W{1'b0}};
      else if (frameEnd && cErr && ~&cparCnt_q)
        cparCnt_q <= cparCnt_q + 1'b1;
      if (wrFebe) febeCnt_q <= {CNT_W{1'b0}};
      else if (frameEnd && febeErr && ~&febeCnt_q)
        febeCnt_q <= febeCnt_q + 1'b1;
    end
  end

  // Transmit feedback: alarm indication and far block error request
  always @(posedge mclk) begin
    if (sys_rst) begin
      rxAlarmIndication <= 1'b0;
      febeRequest <= 1'b0;
    end else begin
      rxAlarmIndication <= (signal_loss & raiEn[0]) | (sef_q & raiEn[1]) |
                           (lof_q & raiEn[2]) | (ais_q & raiEn[3]);
      febeRequest <= frameEnd & ctrl_q[`CTRL_FAR_BLOCK_ERROR_EN] &
                     (cErr | (frmInc != 6'h00));
    end
  end

  // Control and change flags; a new change beats a clearing write
  always @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= `CTRL_RESET;
      change_q <= 12'h000;
      statusPrev_q <= 12'h000;
    end else begin
      statusPrev_q <= status;
      if (wrCtrl) begin
        if (wStrb_q[0]) ctrl_q[7:0] <= wData_q[7:0];
        if (wStrb_q[1]) ctrl_q[11:8] <= {wData_q[11], 1'b0, wData_q[9:8]};
      end
      change_q <= (change_q & ~(wrChange && wStrb_q[0] ? {4'h0, wData_q[7:0]}
                   : 12'h000) & ~(wrChange && wStrb_q[1]
                   ? {wData_q[11:8], 8'h00} : 12'h000))
                  | (status ^ statusPrev_q);
    end
  end

  // AXI4-Lite handshakes
  always @(posedge mclk) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0; wHeld_q <= 1'b0; awAddr_q <= 8'h00;
      wData_q <= 32'h0; wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0; s_axi_rresp <= 2'h0; s_axi_rdata <= 32'h0;
    end else begin
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1; awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1; wData_q <= s_axi_wdata; wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0; awHeld_q <= 1'b0; wHeld_q <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `REG_CTRL:     s_axi_rdata <= {20'h0, ctrl_q};
          `REG_STATUS:   s_axi_rdata <= {20'h0, status};
          `REG_CHANGE:   s_axi_rdata <= {20'h0, change_q};
          `REG_FRM_CNT:  s_axi_rdata <= {{(32-CNT_W){1'b0}}, frmCnt_q};
          `REG_PAR_CNT:  s_axi_rdata <= {{(32-CNT_W){1'b0}}, parCnt_q};
          `REG_CPAR_CNT: s_axi_rdata <= {{(32-CNT_W){1'b0}}, cparCnt_q};
          `REG_FAR_BLOCK_ERROR_CNT: s_axi_rdata <= {{(32-CNT_W){1'b0}}, febeCnt_q};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### verif/ds3_rx_perf_monitor_props.sv
// Port-level checks for the receive performance monitor
`timescale 1ns/1ps
module ds3_rx_perf_monitor_props (
  input wire        mclk,
  input wire        sys_rst,
  input wire        frameEnd,
  input wire        febeRequest,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Both write channels handed over at one edge
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_far_block_error_after_end: assert property (febeRequest |-> $past(frameEnd))
    else $error("far block request without frame end");
  a_far_block_error_one_cycle: assert property (febeRequest |=> !febeRequest)
    else $error("far block request longer than one cycle");
  a_write_answer: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_busy_no_take: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  a_read_answer: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_no_read_take: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while data pending");
endmodule
bind ds3_rx_perf_monitor ds3_rx_perf_monitor_props ds3_rx_perf_monitor_props_i (.*);

// ### verif/ds3_line_source.sv
// Remote transmitter model: tagged DS3 frames with chosen faults
`timescale 1ns/1ps
module ds3_line_source (
  input  wire       mclk,
  output reg        bitValid,
  output reg        lineBit,
  output reg  [2:0] ohType,
  output reg  [2:0] ohSub,
  output reg  [1:0] ohPos,
  output reg        frameEnd
);
  reg acc, last;
  reg [2:0] subV;
  initial {bitValid, lineBit, ohType, ohSub, ohPos, frameEnd, acc} = 0;
  // One bit per cycle; payload bits feed the running parity
  task bit1(input integer t, input integer p, input b);
    begin
      @(posedge mclk);
      bitValid <= 1'b1;
      ohType <= t[2:0];
      ohPos <= p[1:0];
      ohSub <= subV;
      lineBit <= b;
      if (t == 0) acc = acc ^ b;
    end
  endtask
  // Overhead bit, then two payload bits aligned to it
  task put(input integer t, input integer p, input b, input [1:0] pay);
    begin
      bit1(t, p, b);
      bit1(0, 0, pay != 2'h2);
      bit1(0, 0, pay != 2'h0);
    end
  endtask
  // Shortened frame keeping the overhead layout of seven subframes
  task frame(input [1:0] pay, input xv, input allZ, input pInv,
             input cInv, input c4v, input integer fErr, input integer mErr);
    integer s, k;
    begin
      last = acc;
      acc = 1'b0;
      for (s = 1; s < 8; s = s + 1) begin
        subV = s[2:0];
        if (s < 3) put(3, s - 1, xv, pay);
        else if (s < 5) put(4, s - 3, (~allZ & last) ^ pInv, pay);
        else put(2, s - 5, (s == 6) ^ (s - 5 < mErr), pay);
        for (k = 0; k < 4; k = k + 1) begin
          put(1, k, (k == 0 || k == 3) ^ ((s - 1) * 4 + k < fErr), pay);
          if (k < 3) put(5, k, allZ ? 1'b0 : s == 3 ? last ^ cInv
                         : s == 4 ? c4v : 1'b1, pay);
        end
      end
      @(posedge mclk);
      bitValid <= 1'b0;
      lineBit <= ~lineBit; // Released line shows no stale bit
      frameEnd <= 1'b1;
      @(posedge mclk);
      frameEnd <= 1'b0;
    end
  endtask
endmodule

// ### verif/ds3_rx_perf_monitor_tb.sv
// Register-level bench for the receive performance monitor
`timescale 1ns/1ps
module ds3_rx_perf_monitor_tb;
  reg mclk, sys_rst, frameLoad, loadAlignDiff, decoderActive, decoderLos;
  reg rxFormatCbit, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, d;
  reg [3:0] s_axi_wstrb;
  reg [1:0] r;
  wire bitValid, lineBit, frameEnd, rxAlarmIndication, febeRequest;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid;
  wire [2:0] ohType, ohSub;
  wire [1:0] ohPos, s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer fails, comparisons, febeSeen, febeBase, i;
  // Short millisecond keeps frame loss timing cheap
  ds3_rx_perf_monitor #(.MS_CYCLES(20)) ds3_rx_perf_monitor_i (.*);
  ds3_line_source ds3_line_source_i (.*);
  always #12.5 mclk = ~mclk;
  // Far block requests seen; only this process drives the count
  always @(posedge mclk) begin
    if (sys_rst)
      febeSeen <= 0;
    else if (febeRequest === 1'b1)
      febeSeen <= febeSeen + 1;
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // Address and data offered together, each dropped once taken
  task wr(input [7:0] a, input [31:0] v, input [1:0] er);
    begin
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge mclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge mclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(d, e);
    end
  endtask
  task stat(input integer b, input e);
    begin
      rd(8'h04);
      chk({31'h0, d[b]}, {31'h0, e});
    end
  endtask
  task ld(input diff);
    begin
      @(posedge mclk);
      frameLoad <= 1'b1;
      loadAlignDiff <= diff;
      @(posedge mclk);
      frameLoad <= 1'b0;
    end
  endtask
  // Status bit must flip exactly at the last frame of the run
  task run(input integer n, input [1:0] pay, input xv, input allZ,
           input integer b, input e);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        ds3_line_source_i.frame(pay, xv, allZ, 0, 0, 1, 0, 0);
        stat(b, (k == n - 1) ? e : ~e);
      end
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Hang guard, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge mclk);
    fails = fails + 1;
    conclude;
  end
  initial begin
    {mclk, frameLoad, loadAlignDiff, decoderActive, decoderLos} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {fails, comparisons} = 0;
    s_axi_wstrb = 4'hf;
    rxFormatCbit = 1'b1;
    sys_rst = 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h00);
    chk(d & 32'hfffffbff, 32'hbc3);
    rc(8'h40, 32'h0);
    chk({30'h0, r}, 32'h2);
    wr(8'h04, 32'h0, 2'b10);
    wr(8'h00, 32'hbd3, 2'b00);
    ld(0);
    // Resync holds OOF through the misalign option until a clean frame
    wr(8'h00, 32'hfd3, 2'b00);
    stat(1, 1);
    run(1, 2, 1, 0, 1, 0);
    wr(8'h00, 32'hfd3, 2'b00);
    rc(8'h04, 32'hf);
    chk({28'h0, d[3:0]}, 32'hf);
    ld(0);
    run(1, 2, 1, 0, 2, 0);
    stat(3, 0);
    for (i = 12; i < 28; i = i + 4) wr(i[7:0], 32'h0, 2'b00);
    febeBase = febeSeen;
    ds3_line_source_i.frame(2, 1, 0, 1, 1, 0, 2, 1);
    rc(8'h0c, 32'h3);
    rc(8'h10, 32'h1);
    rc(8'h14, 32'h1);
    rc(8'h18, 32'h1);
    chk(febeSeen - febeBase, 32'h1);
    wr(8'h00, 32'hbf3, 2'b00);
    wr(8'h0c, 32'h0, 2'b00);
    ds3_line_source_i.frame(2, 1, 0, 0, 0, 1, 2, 3);
    rc(8'h0c, 32'h3);
    stat(0, 1);
    stat(1, 1);
    ld(1);
    stat(1, 0);
    rd(8'h08);
    chk({31'h0, d[11]}, 32'h1);
    run(4, 2, 0, 0, 8, 1);
    run(4, 2, 1, 0, 8, 0);
    ld(0);
    run(10, 0, 1, 1, 5, 1);
    chk({31'h0, rxAlarmIndication}, 32'h1);
    wr(8'h00, 32'h9f3, 2'b00);
    repeat (3) @(posedge mclk);
    chk({31'h0, rxAlarmIndication}, 32'h0);
    wr(8'h00, 32'hbf3, 2'b00);
    run(10, 2, 1, 0, 5, 0);
    run(10, 1, 1, 0, 7, 1);
    rxFormatCbit <= 1'b0;
    run(1, 1, 1, 0, 9, 1);
    stat(7, 1);
    rxFormatCbit <= 1'b1;
    run(1, 1, 1, 0, 9, 0);
    decoderActive <= 1'b1;
    decoderLos <= 1'b1;
    stat(4, 1);
    chk({31'h0, rxAlarmIndication}, 32'h1);
    decoderActive <= 1'b0;
    stat(4, 0);
    // App id: one C11 zero frame restarts the run of ones
    ds3_line_source_i.frame(0, 1, 1, 0, 0, 1, 0, 0);
    run(31, 2, 1, 0, 10, 1);
    run(4, 0, 1, 1, 10, 0);
    // Frame loss with T of one tick; absence must reach the next tick
    wr(8'h00, 32'hff7, 2'b00);
    repeat (25) @(posedge mclk);
    stat(3, 1);
    ds3_line_source_i.frame(2, 1, 0, 0, 0, 1, 0, 0);
    stat(3, 1);
    repeat (25) @(posedge mclk);
    stat(3, 0);
    conclude;
  end
endmodule
